// ### pmsdi_pkg.sv
// Purpose: constants shared by the MAC-side data interface
// Assumes: the 10 MHz system clock stands in for every interface clock
// Notes: rates above half this clock collapse to one cycle per half period
package pmsdi_pkg;
	// ==========================================================
	// Interface modes
	typedef enum logic [1:0] {
		PMSDI_MII = 2'b00,
		PMSDI_RMII = 2'b01,
		PMSDI_SERIAL_10M_MODE = 2'b10
	} pmsdi_mode_e;

	// ==========================================================
	// Rates and timing
	localparam int unsigned CLK_KHZ = 10000;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned F_MII100_KHZ = 25000;
	localparam int unsigned F_MII10_KHZ = 2500;
	localparam int unsigned F_SER_KHZ = 10000;
	localparam int unsigned F_REF_RMII_KHZ = 50000;
	localparam int unsigned HB_NS = 1000;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned HB_W = 4;
	// Longest time, rounded down, at least one cycle
	localparam int unsigned HB_CYC_I = (HB_NS / CLK_NS < 1) ? 1 : HB_NS / CLK_NS;
	localparam logic [HB_W-1:0] HB_CYC = HB_W'(HB_CYC_I);

	// ==========================================================
	// Data layout
	localparam int unsigned DATA_W = 4;
	localparam logic [1:0] RMII_CORRUPT = 2'h3;
	localparam logic [3:0] DATA_ZERO = 4'h0;

	// Half period of a generated clock in system cycles
	function automatic logic [DIV_W-1:0] half_cycles(input int unsigned f_khz);
		int unsigned h;
		h = CLK_KHZ / (2 * f_khz);
		half_cycles = (h < 1) ? DIV_W'(1) : DIV_W'(h);
	endfunction : half_cycles

	// Interface clock half period for a mode and speed
	function automatic logic [DIV_W-1:0] mode_half(input pmsdi_mode_e m, input logic spd100);
		if (m == PMSDI_SERIAL_10M_MODE) begin
			mode_half = half_cycles(F_SER_KHZ);
		end else if (spd100) begin
			mode_half = half_cycles(F_MII100_KHZ);
		end else begin
			mode_half = half_cycles(F_MII10_KHZ);
		end
	endfunction : mode_half
endpackage : pmsdi_pkg

// ### pmsdi_top.sv
// Purpose: MAC-facing data interface of a dual 10/100 transceiver
// Assumes: CLOCK is also the reference clock input used in RMII
// Notes: line receive side is a valid/ready stream and is buffered; line transmit side has valid only
`timescale 1ns/100ps
module pmsdi_top #(
	parameter int unsigned NPORTS = 2,
	parameter int unsigned BUF_DEPTH = 2
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// Static configuration per port
	input wire logic [2*NPORTS-1:0] MODE,
	input wire logic [NPORTS-1:0] SPEED_100,
	input wire logic [NPORTS-1:0] FULL_DUPLEX,
	input wire logic [NPORTS-1:0] HEARTBEAT_EN,
	// MAC transmit side
	input wire logic [NPORTS-1:0] TX_EN,
	input wire logic [4*NPORTS-1:0] TXD,
	output logic [NPORTS-1:0] TX_CLK,
	// MAC receive side
	output logic [NPORTS-1:0] RX_CLK,
	output logic [NPORTS-1:0] RX_DV,
	output logic [NPORTS-1:0] RX_ER,
	output logic [4*NPORTS-1:0] RXD,
	output logic [NPORTS-1:0] CRS,
	output logic [NPORTS-1:0] COL,
	// Line transmit stream
	output logic [NPORTS-1:0] LINE_TX_VALID,
	output logic [4*NPORTS-1:0] LINE_TX_DATA,
	output logic [NPORTS-1:0] LINE_TX_ACTIVE,
	// Line receive stream
	input wire logic [NPORTS-1:0] LINE_RX_VALID,
	output logic [NPORTS-1:0] LINE_RX_READY,
	input wire logic [4*NPORTS-1:0] LINE_RX_DATA,
	input wire logic [NPORTS-1:0] LINE_RX_SYMERR,
	input wire logic [NPORTS-1:0] LINE_RX_CARRIER,
	input wire logic [NPORTS-1:0] LINE_RX_FALSE_CARRIER
);
	localparam int unsigned AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int unsigned BW = pmsdi_pkg::DATA_W + 1;

	// ==========================================================
	// Parameter checks
	if (NPORTS < 1 || BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad
		$error("pmsdi_top: NPORTS>=1 and BUF_DEPTH a power of two >=2");
	end

	typedef enum logic [1:0] {
		HB_IDLE = 2'b00,
		HB_PULSE = 2'b01
	} pmsdi_hb_e;

	// ==========================================================
	// Per-port logic; ports share nothing but the clock and reset
	// independent port copies
	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		pmsdi_pkg::pmsdi_mode_e mode;
		logic [pmsdi_pkg::DIV_W-1:0] half;
		logic is_rmii;
		logic is_ser;
		assign mode = pmsdi_pkg::pmsdi_mode_e'(MODE[2*p +: 2]);
		assign half = pmsdi_pkg::mode_half(mode, SPEED_100[p]);
		assign is_rmii = (mode == pmsdi_pkg::PMSDI_RMII);
		assign is_ser = (mode == pmsdi_pkg::PMSDI_SERIAL_10M_MODE);

		// ======================================================
		// Clock generation
		logic [pmsdi_pkg::DIV_W-1:0] tdiv_q, tdiv_d, rdiv_q, rdiv_d;
		logic tclk_q, tclk_d, rclk_q, rclk_d;
		logic t_rise, r_fall;

		// Dividers; in RMII the outputs rest low and every cycle is an edge
		always_comb begin
			tdiv_d = tdiv_q;
			tclk_d = tclk_q;
			rdiv_d = rdiv_q;
			rclk_d = rclk_q;
			t_rise = 1'b0;
			r_fall = 1'b0;
			if (is_rmii) begin
				tdiv_d = '0;
				rdiv_d = '0;
				tclk_d = 1'b0;
				rclk_d = 1'b0;
				t_rise = 1'b1;
				r_fall = 1'b1;
			end else begin
				if (tdiv_q >= half - 1'b1) begin
					tdiv_d = '0;
					tclk_d = ~tclk_q;
					t_rise = ~tclk_q;
				end else begin
					tdiv_d = tdiv_q + 1'b1;
				end
				if (rdiv_q >= half - 1'b1) begin
					rdiv_d = '0;
					rclk_d = ~rclk_q;
					r_fall = rclk_q;
				end else begin
					rdiv_d = rdiv_q + 1'b1;
				end
			end
		end

		always_ff @(posedge CLOCK or negedge RST_B) begin
			if (!RST_B) begin
				tdiv_q <= '0;
				tclk_q <= 1'b0;
				rdiv_q <= '0;
				rclk_q <= 1'b0;
			end else begin
				tdiv_q <= tdiv_d;
				tclk_q <= tclk_d;
				rdiv_q <= rdiv_d;
				rclk_q <= rclk_d;
			end
		end

		assign TX_CLK[p] = tclk_q;
		assign RX_CLK[p] = rclk_q;

		// ======================================================
		// Transmit sampling toward the line
		logic txv_q, txv_d, txa_q, txa_d;
		logic [3:0] txd_q, txd_d;

		// Sample at the rising edge the MAC launches against
		always_comb begin
			txv_d = 1'b0;
			txa_d = txa_q;
			txd_d = txd_q;
			if (t_rise) begin
				txv_d = TX_EN[p];
				txa_d = TX_EN[p];
				// MII and serial on transmit clock
				if (is_rmii) begin
					txd_d = {2'h0, TXD[4*p +: 2]};
				end else if (is_ser) begin
					txd_d = {3'h0, TXD[4*p]};
				end else begin
					txd_d = TXD[4*p +: 4];
				end
			end
		end

		always_ff @(posedge CLOCK or negedge RST_B) begin
			if (!RST_B) begin
				txv_q <= 1'b0;
				txa_q <= 1'b0;
				txd_q <= pmsdi_pkg::DATA_ZERO;
			end else begin
				txv_q <= txv_d;
				txa_q <= txa_d;
				txd_q <= txd_d;
			end
		end

		assign LINE_TX_VALID[p] = txv_q;
		assign LINE_TX_ACTIVE[p] = txa_q;
		assign LINE_TX_DATA[4*p +: 4] = txd_q;

		// ======================================================
		// Receive buffer; drained once per receive clock period
		logic [BW-1:0] mem_q [BUF_DEPTH];
		logic [BW-1:0] mem_d [BUF_DEPTH];
		logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
		logic [AW:0] cnt_q, cnt_d;
		logic push, pop;
		logic [BW-1:0] head;

		assign LINE_RX_READY[p] = (cnt_q < (AW+1)'(BUF_DEPTH));
		assign push = LINE_RX_VALID[p] & LINE_RX_READY[p];
		assign pop = r_fall & (cnt_q != '0);
		assign head = mem_q[rp_q];

		// Pointers wrap naturally since the depth is a power of two
		always_comb begin
			mem_d = mem_q;
			wp_d = wp_q;
			rp_d = rp_q;
			cnt_d = cnt_q;
			if (push) begin
				mem_d[wp_q] = {LINE_RX_SYMERR[p], LINE_RX_DATA[4*p +: 4]};
				wp_d = wp_q + 1'b1;
			end
			if (pop) begin
				rp_d = rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_d = cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_d = cnt_q - 1'b1;
			end
		end

		always_ff @(posedge CLOCK or negedge RST_B) begin
			if (!RST_B) begin
				for (int i = 0; i < BUF_DEPTH; i++) begin
					mem_q[i] <= '0;
				end
				wp_q <= '0;
				rp_q <= '0;
				cnt_q <= '0;
			end else begin
				mem_q <= mem_d;
				wp_q <= wp_d;
				rp_q <= rp_d;
				cnt_q <= cnt_d;
			end
		end

		// ======================================================
		// Receive outputs, launched on the falling edge
		logic [3:0] rxd_q, rxd_d;
		logic dv_q, dv_d, er_q, er_d, crs_q, crs_d;
		logic h_err;
		assign h_err = head[BW-1];

		always_comb begin
			rxd_d = rxd_q;
			dv_d = dv_q;
			er_d = er_q;
			crs_d = crs_q;
			if (r_fall) begin
				crs_d = LINE_RX_CARRIER[p];
				dv_d = 1'b0;
				er_d = 1'b0;
				rxd_d = pmsdi_pkg::DATA_ZERO;
				if (is_ser) begin
					if (pop) begin
						rxd_d = {3'h0, head[0]};
					end
				end else if (pop) begin
					dv_d = 1'b1;
					er_d = h_err & SPEED_100[p];
					if (is_rmii) begin
						rxd_d = {2'h0, head[1:0]};
						if (h_err) begin
							rxd_d[1:0] = head[1:0] ^ pmsdi_pkg::RMII_CORRUPT;
						end
						crs_d = 1'b1;
					end else begin
						rxd_d = head[3:0];
					end
				end else if (is_rmii) begin
					er_d = LINE_RX_FALSE_CARRIER[p];
				end
			end
		end

		always_ff @(posedge CLOCK or negedge RST_B) begin
			if (!RST_B) begin
				rxd_q <= pmsdi_pkg::DATA_ZERO;
				dv_q <= 1'b0;
				er_q <= 1'b0;
				crs_q <= 1'b0;
			end else begin
				rxd_q <= rxd_d;
				dv_q <= dv_d;
				er_q <= er_d;
				crs_q <= crs_d;
			end
		end

		assign RXD[4*p +: 4] = rxd_q;
		assign RX_DV[p] = dv_q;
		assign RX_ER[p] = er_q;
		assign CRS[p] = crs_q;

		// ======================================================
		// Collision and heartbeat
		pmsdi_hb_e hb_q, hb_d;
		logic [pmsdi_pkg::HB_W-1:0] hbc_q, hbc_d;
		logic col_q, col_d;
		logic half_dup;
		// RMII has no collision pin; the MAC works it out itself
		assign half_dup = ~FULL_DUPLEX[p] & ~is_rmii;

		always_comb begin
			hb_d = hb_q;
			hbc_d = hbc_q;
			case (hb_q)
				HB_IDLE: begin
					if (half_dup && !SPEED_100[p] && HEARTBEAT_EN[p] && txa_q && !txa_d) begin
						hb_d = HB_PULSE;
						hbc_d = pmsdi_pkg::HB_CYC - 1'b1;
					end
				end
				HB_PULSE: begin
					if (hbc_q == '0 || !half_dup) begin
						hb_d = HB_IDLE;
					end else begin
						hbc_d = hbc_q - 1'b1;
					end
				end
				default: begin
					hb_d = HB_IDLE;
				end
			endcase
			col_d = half_dup & ((txa_q & LINE_RX_CARRIER[p]) | (hb_q == HB_PULSE));
		end

		always_ff @(posedge CLOCK or negedge RST_B) begin
			if (!RST_B) begin
				hb_q <= HB_IDLE;
				hbc_q <= '0;
				col_q <= 1'b0;
			end else begin
				hb_q <= hb_d;
				hbc_q <= hbc_d;
				col_q <= col_d;
			end
		end

		assign COL[p] = col_q;
	end
endmodule : pmsdi_top

// ### pmsdi_monitor.sv
// Purpose: port checker for the MAC-side data interface
// Assumes: one port, mode static between resets
// Notes: watches port 0 only
`timescale 1ns/100ps
module pmsdi_monitor #(
	parameter int unsigned NPORTS = 1
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// Configuration
	input wire logic [2*NPORTS-1:0] MODE,
	input wire logic [NPORTS-1:0] SPEED_100,
	input wire logic [NPORTS-1:0] FULL_DUPLEX,
	input wire logic [NPORTS-1:0] HEARTBEAT_EN,
	// MAC side
	input wire logic [NPORTS-1:0] TX_EN,
	input wire logic [4*NPORTS-1:0] TXD,
	input wire logic [NPORTS-1:0] TX_CLK,
	input wire logic [NPORTS-1:0] RX_CLK,
	input wire logic [NPORTS-1:0] RX_DV,
	input wire logic [NPORTS-1:0] RX_ER,
	input wire logic [4*NPORTS-1:0] RXD,
	input wire logic [NPORTS-1:0] CRS,
	input wire logic [NPORTS-1:0] COL,
	// Line side
	input wire logic [NPORTS-1:0] LINE_TX_VALID,
	input wire logic [4*NPORTS-1:0] LINE_TX_DATA,
	input wire logic [NPORTS-1:0] LINE_TX_ACTIVE,
	input wire logic [NPORTS-1:0] LINE_RX_CARRIER,
	input wire logic [NPORTS-1:0] LINE_RX_FALSE_CARRIER
);
	// Mode decode, static while out of reset
	wire logic rmii = (MODE[1:0] == 2'h1);
	wire logic ser = (MODE[1:0] == 2'h2);
	wire logic hdx = !FULL_DUPLEX[0] && !rmii;
	wire logic [1:0] txd2 = TXD[1:0];
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	// ==========================================
	// Heartbeat steps: end of transmit, then a pulse of ten cycles
	sequence hb_end;
		$fell(LINE_TX_ACTIVE[0]) && hdx && HEARTBEAT_EN[0] && !SPEED_100[0] && !ser && !LINE_RX_CARRIER[0];
	endsequence
	sequence hb_pulse;
		##[0:2] $rose(COL[0]) ##0 COL[0] [*8] ##1 COL[0] ##1 COL[0] ##1 !COL[0];
	endsequence
	col_quiet_a: assert property (FULL_DUPLEX[0] || rmii |-> !COL[0])
		else $error("COL high in full duplex or RMII");
	col_sim_a: assert property (hdx && LINE_TX_ACTIVE[0] && LINE_RX_CARRIER[0] |=> COL[0])
		else $error("no COL on simultaneous activity");
	sqe_pulse_a: assert property (hb_end |-> hb_pulse)
		else $error("heartbeat pulse wrong");
	clk_rmii_a: assert property (rmii |-> !TX_CLK[0] && !RX_CLK[0])
		else $error("clock output toggles in RMII");
	tx_sample_a: assert property (!rmii && $rose(TX_CLK[0]) |->
		LINE_TX_VALID[0] == $past(TX_EN[0]) && LINE_TX_ACTIVE[0] == $past(TX_EN[0]))
		else $error("transmit not sampled at clock rise");
	tx_rmii_a: assert property (rmii && $past(RST_B) |-> LINE_TX_VALID[0] == $past(TX_EN[0]) &&
		(!LINE_TX_VALID[0] || LINE_TX_DATA[3:0] == {2'h0, $past(txd2)}))
		else $error("RMII dibit not taken every cycle");
	rx_serial_a: assert property (ser |-> RXD[3:1] == 3'h0 && !RX_DV[0] && !RX_ER[0])
		else $error("serial receive uses unused outputs");
	crs_dv_a: assert property (rmii && RX_DV[0] |-> CRS[0])
		else $error("CRS low with RMII data");
	false_car_a: assert property (rmii && !RX_DV[0] && $past(RST_B) |->
		RX_ER[0] == $past(LINE_RX_FALSE_CARRIER[0]))
		else $error("false carrier not on RX_ER");
	rx_er10_a: assert property (!rmii && !SPEED_100[0] |-> !RX_ER[0])
		else $error("RX_ER at 10 Mb/s");
	crs_mii_a: assert property (!rmii && $fell(RX_CLK[0]) |-> CRS[0] == $past(LINE_RX_CARRIER[0]))
		else $error("CRS does not follow carrier");
	// Fast rates floor at a half period of one system cycle
	clk_fast_a: assert property (!rmii && (ser || SPEED_100[0]) |=>
		TX_CLK[0] != $past(TX_CLK[0]) && RX_CLK[0] != $past(RX_CLK[0]))
		else $error("fast interface clock does not toggle each cycle");
endmodule : pmsdi_monitor
bind pmsdi_top pmsdi_monitor #(.NPORTS(NPORTS)) pmsdi_monitor_i (.CLOCK(CLOCK), .RST_B(RST_B), .MODE(MODE),
	.SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX), .HEARTBEAT_EN(HEARTBEAT_EN), .TX_EN(TX_EN), .TXD(TXD),
	.TX_CLK(TX_CLK), .RX_CLK(RX_CLK), .RX_DV(RX_DV), .RX_ER(RX_ER), .RXD(RXD), .CRS(CRS), .COL(COL),
	.LINE_TX_VALID(LINE_TX_VALID), .LINE_TX_DATA(LINE_TX_DATA), .LINE_TX_ACTIVE(LINE_TX_ACTIVE),
	.LINE_RX_CARRIER(LINE_RX_CARRIER), .LINE_RX_FALSE_CARRIER(LINE_RX_FALSE_CARRIER));

// ### pmsdi_mac_model.sv
// Purpose: MAC transmit side launching words on the device clock
// Assumes: one port
// Notes: changes TX_EN and TXD one cycle after each sample edge
`timescale 1ns/100ps
module pmsdi_mac_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Next word from the bench
	input wire logic rmii,
	input wire logic next_en,
	input wire logic [3:0] next_d,
	// Device side
	input wire logic tx_clk,
	input wire logic crs_dv,
	output logic tx_en,
	output logic [3:0] txd,
	output logic step,
	// MAC view of a collision
	output logic col_seen
);
	logic clk_q;
	// no collision pin in RMII, MAC forms it
	assign col_seen = rmii && tx_en && crs_dv;
	// launch after a clock rise, idle data is inverted each step
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clk_q <= 1'b0;
			tx_en <= 1'b0;
			txd <= 4'h0;
			step <= 1'b0;
		end else begin
			clk_q <= tx_clk;
			step <= rmii || (tx_clk && !clk_q);
			if (rmii || (tx_clk && !clk_q)) begin
				tx_en <= next_en;
				txd <= next_en ? next_d : ~txd;
			end
		end
	end
endmodule : pmsdi_mac_model

// ### tb_top.sv
// Purpose: self-checking bench for the MAC-side data interface
// Assumes: one port, five static configurations
// Notes: expected words are queued when launched
`timescale 1ns/100ps
module tb_top;
	logic clock, rst_b, run, rx_valid, rx_serr, carrier, fcar, next_en, ne, step, tx_en, mac_col;
	logic tx_clk, rx_clk, rx_clk_p, rx_dv, rx_er, crs, col, ltx_valid, ltx_active, rx_ready, spd, fdx, hb;
	logic [1:0] mode;
	logic [3:0] rx_data, next_d, nd, txd, rxd, ltx_data;
	logic [3:0] txq[$];
	logic [4:0] rxq[$];
	// Mode, 100M, full duplex, heartbeat enable
	logic [4:0] cfg[5] = '{5'h04, 5'h01, 5'h0c, 5'h12, 5'h03};
	int n_errors, checks_done, cnt, refusals, mac_cols;
	integer seed = 7190;
	pmsdi_top #(.NPORTS(1), .BUF_DEPTH(2)) pmsdi_top_i (.CLOCK(clock), .RST_B(rst_b), .MODE(mode),
		.SPEED_100(spd), .FULL_DUPLEX(fdx), .HEARTBEAT_EN(hb), .TX_EN(tx_en), .TXD(txd), .TX_CLK(tx_clk),
		.RX_CLK(rx_clk), .RX_DV(rx_dv), .RX_ER(rx_er), .RXD(rxd), .CRS(crs), .COL(col),
		.LINE_TX_VALID(ltx_valid), .LINE_TX_DATA(ltx_data), .LINE_TX_ACTIVE(ltx_active),
		.LINE_RX_VALID(rx_valid), .LINE_RX_READY(rx_ready), .LINE_RX_DATA(rx_data),
		.LINE_RX_SYMERR(rx_serr), .LINE_RX_CARRIER(carrier), .LINE_RX_FALSE_CARRIER(fcar));
	pmsdi_mac_model pmsdi_mac_model_i (.clock(clock), .rst_b(rst_b), .rmii(mode == 2'h1), .next_en(next_en),
		.next_d(next_d), .tx_clk(tx_clk), .crs_dv(crs), .tx_en(tx_en), .txd(txd), .step(step), .col_seen(mac_col));
	// ==========================================
	// Comparison and verdict
	task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude;
		if (n_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Driver: random line words and MAC frames, noted when launched
	always @(posedge clock) begin
		if (rst_b) begin
			if (rx_valid && rx_ready && mode != 2'h2) begin
				rxq.push_back({rx_serr & spd, mode == 2'h1 ? {2'h0, rx_data[1:0] ^ {2{rx_serr}}} : rx_data});
			end
			if (!rx_ready) refusals++;
			if (!rx_valid || rx_ready) begin
				rx_valid <= run && (($random(seed) & 3) != 0);
				rx_data <= 4'($random(seed));
				rx_serr <= 1'($random(seed));
			end
			carrier <= !hb && 1'($random(seed));
			fcar <= 1'($random(seed));
			if (step) begin
				cnt++;
				ne = run && (cnt % 16) < 4;
				nd = 4'($random(seed));
				if (ne) txq.push_back(mode == 2'h1 ? {2'h0, nd[1:0]} : mode == 2'h2 ? {3'h0, nd[0]} : nd);
				next_en <= ne;
				next_d <= nd;
			end
		end
	end
	// Observer: each word that leaves takes the oldest note
	always @(posedge clock) begin
		rx_clk_p <= rx_clk;
		// MAC-side collisions from CRS_DV and TX_EN
		if (rst_b && mac_col) mac_cols++;
		if (rst_b && ltx_valid) begin
			check("line tx data", {1'b0, ltx_data}, txq.size() ? {1'b0, txq.pop_front()} : 5'hx);
		end
		if (rst_b && rx_dv && (mode == 2'h1 || (rx_clk_p && !rx_clk))) begin
			check("rx error and data", {rx_er, rxd}, rxq.size() ? rxq.pop_front() : 5'hx);
		end
	end
	// Main sequence: each configuration after its own reset
	initial begin
		{rst_b, run, rx_valid, rx_data, rx_serr, carrier, fcar, next_en, next_d} = '0;
		{mode, spd, fdx, hb} = cfg[0];
		rx_clk_p = 1'b0;
		for (int k = 0; k < 5; k++) begin
			@(posedge clock);
			rst_b <= 1'b0;
			run <= 1'b0;
			{mode, spd, fdx, hb} <= cfg[k];
			repeat (3) @(posedge clock);
			txq.delete();
			rxq.delete();
			refusals = 0;
			mac_cols = 0;
			rst_b <= 1'b1;
			run <= 1'b1;
			repeat (400) @(posedge clock);
			run <= 1'b0;
			repeat (40) @(posedge clock);
			check("tx words left", 5'(txq.size()), 5'h0);
			check("rx words left", 5'(rxq.size()), 5'h0);
			check("ready drained", {4'h0, rx_ready}, 5'h1);
			check("buffer refused", {4'h0, refusals != 0}, {4'h0, cfg[k][4:3] != 2'h1});
			check("mac collision seen", {4'h0, mac_cols != 0}, {4'h0, cfg[k][4:3] == 2'h1});
		end
		conclude();
	end
	// Watchdog well beyond the planned run
	initial begin
		#1000000;
		n_errors++;
		conclude();
	end
endmodule : tb_top
